// ### rtl/dft_regs.vh
// Functional notes
// [R01] Three 8-bit target temperatures, reset 0xa4
// [R02] Six 8-bit zone limits, low 0x01, high 0x7f
// [R03] Below low limit: turn-on temperature rises
// [R04] Above high limit: turn-on temperature falls
// [R05] Flag events below low, above high
// [R06] Short cycle every n, long every 2n
// [R07] Per-channel 3-bit cycle code field placement
// [R08] Code 000 gives 8/16, doubling per step
// [R09] Below target minus hysteresis: hold turn-on
// [R10] Short cycle: drop 2 per 1 rise
// [R11] Rise of 0.25 or less: no drop
// [R12] Long cycle idle in hysteresis band
// [R13] Above target: long cycle drops one degree
// [R14] Back below target: hold turn-on temperature
// [R15] Neutral zone: fixed turn-on temperature used
// [R16] Long-cycle raise needs all four conditions
// [R17] Turn-on clamped: high limit, floor -127/-64
// [R18] Below turn-on: fan off, loop suspended
// [R19] Control bits 7:5 enable each channel
// [R20] Limits use measured temperature encoding
// [R21] Hysteresis is the fan control hysteresis
`ifndef DFT_REGS_VH
`define DFT_REGS_VH
// Register offsets
`define DFT_ADDR_R1_TARGET 8'h33
`define DFT_ADDR_LC_TARGET 8'h34
`define DFT_ADDR_R2_TARGET 8'h35
`define DFT_ADDR_CAL_ONE 8'h36
`define DFT_ADDR_CYC_SEL 8'h37
`define DFT_ADDR_R1_LOW 8'h4e
`define DFT_ADDR_R1_HIGH 8'h4f
`define DFT_ADDR_LC_LOW 8'h50
`define DFT_ADDR_LC_HIGH 8'h51
`define DFT_ADDR_R2_LOW 8'h52
`define DFT_ADDR_R2_HIGH 8'h53
// Reset values
`define DFT_RST_TARGET 8'ha4
`define DFT_RST_LOW 8'h01
`define DFT_RST_HIGH 8'h7f
`define DFT_RST_CAL_ONE 8'h00
`define DFT_RST_CYC_SEL 8'h00
// Field positions
`define DFT_EN_R1_BIT 7
`define DFT_EN_LC_BIT 6
`define DFT_EN_R2_BIT 5
`define DFT_R2_CODE_LSB_BIT 0
// Timing counts in monitoring cycles
`define DFT_SHORT_BASE 12'd8
// Turn-on temperature floors in degrees
`define DFT_FLOOR_TWOS 12'hf81
`define DFT_FLOOR_OFF64 12'hfc0
`endif

// ### rtl/dft_loop.v
`include "dft_regs.vh"

module dft_loop #(
   parameter NCH = 3
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_we,
   input wire reg_re,
   output reg [7:0] reg_rdata,
   // Monitoring timebase and encoding
   input wire monitor_tick,
   input wire offset64_mode,
   // Measured temperatures, 8 integer bits then 2 quarter bits
   input wire [9:0] remote1_temp,
   input wire [9:0] local_temp,
   input wire [9:0] remote2_temp,
   // Fan control hysteresis per channel, whole degrees
   input wire [3:0] remote1_hyst,
   input wire [3:0] local_hyst,
   input wire [3:0] remote2_hyst,
   // Programmed turn-on temperature load
   input wire [7:0] fan_turn_on_temp_set_value,
   input wire remote1_fan_turn_on_temp_set,
   input wire local_fan_turn_on_temp_set,
   input wire remote2_fan_turn_on_temp_set,
   // Adjusted turn-on temperatures
   output wire [7:0] remote1_fan_turn_on_temp,
   output wire [7:0] local_fan_turn_on_temp,
   output wire [7:0] remote2_fan_turn_on_temp,
   // Zone events and fan gating
   output reg [2:0] below_low_flag,
   output reg [2:0] above_high_flag,
   output reg [2:0] fan_off
);

   ////////////////////////////////////////////////////////////////////////////
   // Encoding helpers

   // Register code to signed degrees
   function [11:0] to_deg;
      input [7:0] v;
      input off;
      begin
         if (off) begin
            to_deg = {4'h0, v} - 12'd64;
         end else begin
            to_deg = {{4{v[7]}}, v};
         end
      end
   endfunction

   // Signed degrees back to register code
   function [7:0] from_deg;
      input [11:0] d;
      input off;
      reg [11:0] t;
      begin
         t = d + 12'd64;
         if (off) begin
            from_deg = t[7:0];
         end else begin
            from_deg = d[7:0];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   reg [7:0] target_q [0:2];
   reg [7:0] low_q [0:2];
   reg [7:0] high_q [0:2];
   reg [7:0] cal_one_q;
   reg [7:0] cyc_sel_q;
   reg [7:0] rdata_d;

   // Software writes
   always @(posedge ref_clk) begin
      if (rst) begin
         target_q[0] <= `DFT_RST_TARGET; // R01
         target_q[1] <= `DFT_RST_TARGET; // R01
         target_q[2] <= `DFT_RST_TARGET; // R01
         low_q[0] <= `DFT_RST_LOW; // R02
         low_q[1] <= `DFT_RST_LOW; // R02
         low_q[2] <= `DFT_RST_LOW; // R02
         high_q[0] <= `DFT_RST_HIGH; // R02
         high_q[1] <= `DFT_RST_HIGH; // R02
         high_q[2] <= `DFT_RST_HIGH; // R02
         cal_one_q <= `DFT_RST_CAL_ONE;
         cyc_sel_q <= `DFT_RST_CYC_SEL;
      end else if (reg_we) begin
         case (reg_addr)
            `DFT_ADDR_R1_TARGET: target_q[0] <= reg_wdata;
            `DFT_ADDR_LC_TARGET: target_q[1] <= reg_wdata;
            `DFT_ADDR_R2_TARGET: target_q[2] <= reg_wdata;
            `DFT_ADDR_CAL_ONE: cal_one_q <= reg_wdata;
            `DFT_ADDR_CYC_SEL: cyc_sel_q <= reg_wdata;
            `DFT_ADDR_R1_LOW: low_q[0] <= reg_wdata;
            `DFT_ADDR_R1_HIGH: high_q[0] <= reg_wdata;
            `DFT_ADDR_LC_LOW: low_q[1] <= reg_wdata;
            `DFT_ADDR_LC_HIGH: high_q[1] <= reg_wdata;
            `DFT_ADDR_R2_LOW: low_q[2] <= reg_wdata;
            `DFT_ADDR_R2_HIGH: high_q[2] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read decode, unmapped reads zero
   always @* begin
      case (reg_addr)
         `DFT_ADDR_R1_TARGET: rdata_d = target_q[0];
         `DFT_ADDR_LC_TARGET: rdata_d = target_q[1];
         `DFT_ADDR_R2_TARGET: rdata_d = target_q[2];
         `DFT_ADDR_CAL_ONE: rdata_d = cal_one_q;
         `DFT_ADDR_CYC_SEL: rdata_d = cyc_sel_q;
         `DFT_ADDR_R1_LOW: rdata_d = low_q[0];
         `DFT_ADDR_R1_HIGH: rdata_d = high_q[0];
         `DFT_ADDR_LC_LOW: rdata_d = low_q[1];
         `DFT_ADDR_LC_HIGH: rdata_d = high_q[1];
         `DFT_ADDR_R2_LOW: rdata_d = low_q[2];
         `DFT_ADDR_R2_HIGH: rdata_d = high_q[2];
         default: rdata_d = 8'h00;
      endcase
   end

   // Registered read data
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         reg_rdata <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel fan-out of inputs and control fields

   wire [9:0] temp_w [0:2];
   wire [3:0] hyst_w [0:2];
   wire [2:0] code_w [0:2];
   wire [2:0] enable_w;
   wire [2:0] fan_turn_on_temp_set_w;
   wire [7:0] fan_turn_on_temp_w [0:2];
   wire [2:0] below_low_w;
   wire [2:0] above_high_w;
   wire [2:0] off_w;

   assign temp_w[0] = remote1_temp;
   assign temp_w[1] = local_temp;
   assign temp_w[2] = remote2_temp;
   assign hyst_w[0] = remote1_hyst; // R21
   assign hyst_w[1] = local_hyst; // R21
   assign hyst_w[2] = remote2_hyst; // R21
   // Cycle code placement
   assign code_w[0] = cyc_sel_q[2:0]; // R07
   assign code_w[1] = cyc_sel_q[5:3]; // R07
   assign code_w[2] = {cyc_sel_q[7:6], cal_one_q[`DFT_R2_CODE_LSB_BIT]}; // R07
   // Adaptive enables
   assign enable_w[0] = cal_one_q[`DFT_EN_R1_BIT]; // R19
   assign enable_w[1] = cal_one_q[`DFT_EN_LC_BIT]; // R19
   assign enable_w[2] = cal_one_q[`DFT_EN_R2_BIT]; // R19
   assign fan_turn_on_temp_set_w = {remote2_fan_turn_on_temp_set, local_fan_turn_on_temp_set, remote1_fan_turn_on_temp_set};

   assign remote1_fan_turn_on_temp = fan_turn_on_temp_w[0];
   assign local_fan_turn_on_temp = fan_turn_on_temp_w[1];
   assign remote2_fan_turn_on_temp = fan_turn_on_temp_w[2];

   ////////////////////////////////////////////////////////////////////////////
   // Adjustment loop, one per channel

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         reg [7:0] fan_turn_on_temp_q;
         reg [11:0] prev_q;
         reg [11:0] cnt_q;
         reg [7:0] fan_turn_on_temp_d;
         reg [11:0] cnt_next;
         reg [11:0] short_mask;
         reg [11:0] long_mask;
         reg short_hit;
         reg long_hit;
         reg [11:0] temp_qd;
         reg [11:0] temp_deg;
         reg [11:0] target_deg;
         reg [11:0] low_deg;
         reg [11:0] high_deg;
         reg [11:0] fan_turn_on_temp_deg;
         reg [11:0] target_qd;
         reg [11:0] band_qd;
         reg [11:0] rise_qd;
         reg [11:0] low_qd;
         reg [11:0] high_qd;
         reg [11:0] drop_deg;
         reg [11:0] new_deg;
         reg [11:0] floor_deg;
         reg active;
         reg below_low;
         reg above_high;

         // Decision logic for one monitoring cycle
         always @* begin
            cnt_next = cnt_q + 12'd1;
            short_mask = (`DFT_SHORT_BASE << code_w[g]) - 12'd1; // R08
            long_mask = {short_mask[10:0], 1'b1}; // R08
            short_hit = (cnt_next & short_mask) == 12'd0; // R06
            long_hit = (cnt_next & long_mask) == 12'd0; // R06
            // Zone, band and turn-on compares in signed quarter degrees (floor compare in degrees), shared encoding
            temp_deg = to_deg(temp_w[g][9:2], offset64_mode); // R20
            target_deg = to_deg(target_q[g], offset64_mode); // R20
            low_deg = to_deg(low_q[g], offset64_mode); // R20
            high_deg = to_deg(high_q[g], offset64_mode); // R20
            temp_qd = {temp_deg[9:0], 2'b00} + {10'd0, temp_w[g][1:0]}; // R20
            fan_turn_on_temp_deg = to_deg(fan_turn_on_temp_q, offset64_mode);
            target_qd = {target_deg[9:0], 2'b00}; // R20
            band_qd = target_qd - {6'd0, hyst_w[g], 2'b00}; // R21
            low_qd = {low_deg[9:0], 2'b00}; // R20
            high_qd = {high_deg[9:0], 2'b00}; // R20
            rise_qd = temp_qd - prev_q;
            below_low = $signed(temp_qd) < $signed(low_qd); // R05
            above_high = $signed(temp_qd) > $signed(high_qd); // R05
            active = enable_w[g] && ($signed(temp_qd) > $signed({fan_turn_on_temp_deg, 2'b00})); // R18 R19
            floor_deg = offset64_mode ? `DFT_FLOOR_OFF64 : `DFT_FLOOR_TWOS;
            drop_deg = 12'd0;
            new_deg = fan_turn_on_temp_deg;
            fan_turn_on_temp_d = fan_turn_on_temp_q;
            if (active && short_hit && ($signed(temp_qd) > $signed(band_qd))) begin // R09 R14
               // Quarter-degree rises above one step drop two per degree
               if ($signed(rise_qd) > $signed(12'd1)) begin // R11
                  drop_deg = {1'b0, rise_qd[11:1]}; // R10
               end
            end
            // Long cycle lowers one degree above target or high limit
            if (active && long_hit && (above_high || ($signed(temp_qd) > $signed(target_qd)))) begin // R04 R12 R13
               drop_deg = drop_deg + 12'd1; // R13
            end
            new_deg = fan_turn_on_temp_deg - drop_deg; // R04
            if (active && long_hit && below_low && ($signed({fan_turn_on_temp_deg, 2'b00}) < $signed(high_qd)) &&
                ($signed({fan_turn_on_temp_deg, 2'b00}) < $signed(target_qd)) && (drop_deg == 12'd0)) begin // R16
               new_deg = fan_turn_on_temp_deg + 12'd1; // R03 R17
            end
            // Floor on the way down
            if ($signed(new_deg) < $signed(floor_deg)) begin
               new_deg = floor_deg; // R17
            end
            if (active && (short_hit || long_hit)) begin
               fan_turn_on_temp_d = from_deg(new_deg, offset64_mode);
            end
            if (fan_turn_on_temp_set_w[g]) begin
               fan_turn_on_temp_d = fan_turn_on_temp_set_value; // R15
            end
         end

         // Loop state update on the monitoring timebase
         always @(posedge ref_clk) begin
            if (rst) begin
               fan_turn_on_temp_q <= 8'h00;
               prev_q <= 12'd0;
               cnt_q <= 12'd0;
            end else begin
               if (fan_turn_on_temp_set_w[g]) begin
                  fan_turn_on_temp_q <= fan_turn_on_temp_d;
               end else if (monitor_tick) begin
                  fan_turn_on_temp_q <= fan_turn_on_temp_d;
               end
               if (monitor_tick) begin
                  prev_q <= temp_qd; // R10
                  cnt_q <= cnt_next; // R06
               end
            end
         end

         assign fan_turn_on_temp_w[g] = fan_turn_on_temp_q;
         assign below_low_w[g] = below_low;
         assign above_high_w[g] = above_high;
         assign off_w[g] = $signed(temp_qd) < $signed({fan_turn_on_temp_deg, 2'b00}); // R18
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Zone flags and fan gating, refreshed each monitoring cycle

   always @(posedge ref_clk) begin
      if (rst) begin
         below_low_flag <= 3'b000;
         above_high_flag <= 3'b000;
         fan_off <= 3'b000;
      end else if (monitor_tick) begin
         below_low_flag <= below_low_w; // R05
         above_high_flag <= above_high_w; // R05
         fan_off <= off_w; // R18
      end
   end

endmodule // dft_loop

// ### verification/dft_loop_properties.sv
module dft_props (
   // Clock and reset
   input logic ref_clk,
   input logic rst,
   // Register read side
   input logic reg_re,
   input logic [7:0] reg_rdata,
   // Loop inputs
   input logic monitor_tick,
   input logic offset64_mode,
   input logic [9:0] remote1_temp,
   input logic [7:0] fan_turn_on_temp_set_value,
   input logic remote1_fan_turn_on_temp_set,
   // Loop outputs
   input logic [7:0] remote1_fan_turn_on_temp,
   input logic [2:0] below_low_flag,
   input logic [2:0] above_high_flag,
   input logic [2:0] fan_off
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Flags move only on monitoring ticks
   AST_LOW_HOLD: assert property (!monitor_tick |=> $stable(below_low_flag))
      else $error("low flag moved without tick");
   AST_HIGH_HOLD: assert property (!monitor_tick |=> $stable(above_high_flag))
      else $error("high flag moved without tick");
   AST_OFF_HOLD: assert property (!monitor_tick |=> $stable(fan_off))
      else $error("fan off moved without tick");
   // Turn-on moves only on ticks or loads
   AST_FAN_TURN_ON_TEMP_HOLD: assert property (!monitor_tick && !remote1_fan_turn_on_temp_set |=> $stable(remote1_fan_turn_on_temp))
      else $error("turn-on moved without tick");
   // Below turn-on: loop suspended, fan off
   AST_FAN_TURN_ON_TEMP_SUSPEND: assert property (monitor_tick && !remote1_fan_turn_on_temp_set && !offset64_mode &&
      $signed(remote1_temp[9:2]) < $signed(remote1_fan_turn_on_temp) |=> $stable(remote1_fan_turn_on_temp))
      else $error("turn-on adjusted below turn-on");
   AST_FAN_OFF: assert property (monitor_tick && !offset64_mode &&
      $signed(remote1_temp[9:2]) < $signed(remote1_fan_turn_on_temp) |=> fan_off[0])
      else $error("fan off not set");
   // Raise is at most one degree per tick
   AST_RAISE_STEP: assert property (!remote1_fan_turn_on_temp_set |=>
      $signed(remote1_fan_turn_on_temp) <= $signed($past(remote1_fan_turn_on_temp)) + 9'sd1)
      else $error("turn-on rose by more than one");
   AST_LOAD: assert property (remote1_fan_turn_on_temp_set |=> remote1_fan_turn_on_temp == $past(fan_turn_on_temp_set_value))
      else $error("turn-on load lost");
   AST_RD_HOLD: assert property (!reg_re |=> $stable(reg_rdata))
      else $error("read data moved without read");
endmodule // dft_props

// ### verification/dft_tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst, reg_we, reg_re, tick, off64, tset;
   logic [7:0] addr, wdata, tset_val, rdata, r1_on, lc_on, r2_on;
   logic [9:0] t;
   logic [3:0] h;
   logic [2:0] lowf, highf, fanoff;
   int bad_count, n_tests;
   logic [7:0] ra [11] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53};
   logic [7:0] rv [11] = '{8'ha4, 8'ha4, 8'ha4, 8'h00, 8'h00, 8'h01, 8'h7f, 8'h01, 8'h7f, 8'h01, 8'h7f};
   ////////////////////////////////////////////////////////////
   // Design under test
   dft_loop u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(rdata), .monitor_tick(tick), .offset64_mode(off64), .remote1_temp(t),
      .local_temp(t), .remote2_temp(t), .remote1_hyst(h), .local_hyst(h), .remote2_hyst(h),
      .fan_turn_on_temp_set_value(tset_val), .remote1_fan_turn_on_temp_set(tset), .local_fan_turn_on_temp_set(tset), .remote2_fan_turn_on_temp_set(tset),
      .remote1_fan_turn_on_temp(r1_on), .local_fan_turn_on_temp(lc_on), .remote2_fan_turn_on_temp(r2_on),
      .below_low_flag(lowf), .above_high_flag(highf), .fan_off(fanoff));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////
   // Bench tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      reg_we = 1'b1;
      @(negedge ref_clk);
      reg_we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      addr = a;
      reg_re = 1'b1;
      @(negedge ref_clk);
      reg_re = 1'b0;
      chk(rdata, exp);
   endtask
   task automatic load(input logic [7:0] v);
      @(negedge ref_clk);
      tset_val = v;
      tset = 1'b1;
      @(negedge ref_clk);
      tset = 1'b0;
   endtask
   task automatic ticks(input int n, input logic [9:0] temp);
      t = temp;
      repeat (n) begin
         @(negedge ref_clk);
         tick = 1'b1;
         @(negedge ref_clk);
         tick = 1'b0;
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1; reg_we = 1'b0; reg_re = 1'b0; tick = 1'b0; off64 = 1'b0; tset = 1'b0;
      addr = 8'h00; wdata = 8'h00; tset_val = 8'h00; t = 10'h000; h = 4'h2;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
      rd(8'h00, 8'h00);
      wr(8'h33, 8'h30);
      rd(8'h33, 8'h30);
      wr(8'h36, 8'h80);
      load(8'h20);
      ticks(7, {8'h28, 2'b00});
      chk(r1_on, 8'h20);
      ticks(1, {8'h30, 2'b00});
      chk(r1_on, 8'h10);
      ticks(7, {8'h31, 2'b00});
      ticks(1, {8'h31, 2'b01});
      chk(r1_on, 8'h0f);
      ticks(16, {8'h2f, 2'b00});
      chk(r1_on, 8'h0f);
      wr(8'h4e, 8'h40);
      ticks(16, {8'h28, 2'b00});
      chk(r1_on, 8'h10);
      chk({2'b00, highf, lowf}, 8'h01);
      chk(lc_on, 8'h20);
      chk(r2_on, 8'h20);
      wr(8'h4f, 8'h24);
      ticks(16, {8'h08, 2'b00});
      chk(r1_on, 8'h10);
      chk({5'h00, fanoff}, 8'h07);
      ticks(1, {8'h28, 2'b00});
      chk({5'h00, highf}, 8'h01);
      // Second run with doubled cycle length
      @(negedge ref_clk);
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      wr(8'h33, 8'h30);
      wr(8'h36, 8'h80);
      wr(8'h37, 8'h01);
      rd(8'h37, 8'h01);
      load(8'h20);
      ticks(31, {8'h31, 2'b00});
      chk(r1_on, 8'h20);
      ticks(1, {8'h31, 2'b00});
      chk(r1_on, 8'h1f);
      summarize();
   end
   // Watchdog
   initial begin
      #2000000;
      bad_count++;
      summarize();
   end
endmodule // tb

bind dft_loop dft_props u_props (.ref_clk(ref_clk), .rst(rst), .reg_re(reg_re), .reg_rdata(reg_rdata),
   .monitor_tick(monitor_tick), .offset64_mode(offset64_mode), .remote1_temp(remote1_temp),
   .fan_turn_on_temp_set_value(fan_turn_on_temp_set_value), .remote1_fan_turn_on_temp_set(remote1_fan_turn_on_temp_set),
   .remote1_fan_turn_on_temp(remote1_fan_turn_on_temp), .below_low_flag(below_low_flag),
   .above_high_flag(above_high_flag), .fan_off(fan_off));
